/* cosir_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// - Node state reads as six-bit one-hot field, init lowest, stopped highest.
// - Status bit 6 shows which redundant bus is in use.
// - Receive overrun sets status bit 7 and raises the CAN error event.
// - Status bits 9 and 10 mirror error-passive and bus-off.
// - With self-start set, initialisation ends in operational state.
// - Status bits 23..16 hold receive, 31..24 transmit error counters.
// - PDO rx, PDO tx, SDO end, SDO init, state change drive transfer line.
// - SDO abort, memory fault and CAN error drive the error line.
// - Low-half mask bit at one blocks its event, zero passes it.
// - Writing one to a clear bit clears the matching event.
// - Memory correction enable is zero after start-up; host sets it.
// - Single and double error flags clear on any write to that register.
// - Any write to the trigger register starts the asynchronous transmit PDO.
// - Listed registers reset on power-on, core reset, application reset, bus switch only.
// - Node state, node id, enable reset only at power-on or core reset; active bus is a live input.
// - Writes to the private memory area are rejected.
// - Application objects live in one 512 by 32 memory.
// - Config bit 13 resets the CAN controller; bits 12..10 hold jump width.
// - Read-and-clear fields are cleared by writes, never loaded.
module cosir_regs (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Register port.
  input wire logic [12:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_wr_rejected_out,
  // Reset events.
  input wire logic reset_app_in,
  input wire logic reset_comm_in,
  input wire logic bus_switch_in,
  // Pins.
  input wire logic [7:0] node_id_pins_in,
  // CAN controller.
  input wire logic active_bus_in,
  input wire logic err_passive_in,
  input wire logic bus_off_in,
  input wire logic [7:0] rx_err_cnt_in,
  input wire logic [7:0] tx_err_cnt_in,
  input wire logic rx_overrun_in,
  output logic can_reset_out,
  output logic [2:0] resync_jump_width_out,
  output logic [9:0] bit_timing_out,
  // Protocol engine events.
  input wire logic self_start_flag_in,
  input wire logic init_done_in,
  input wire logic [5:0] state_req_in,
  input wire logic state_req_valid_in,
  input wire logic ev_pdo_rx_in,
  input wire logic ev_pdo_tx_in,
  input wire logic ev_sdo_end_in,
  input wire logic ev_sdo_abort_in,
  input wire logic ev_sdo_init_in,
  input wire logic sdo_download_in,
  input wire logic sdo_upload_in,
  input wire logic mem_single_err_in,
  input wire logic mem_double_err_in,
  output logic mem_correct_en_out,
  output logic tx_pdo_trigger_out,
  output logic [5:0] node_state_out,
  output logic [7:0] node_id_out,
  // Interrupt lines.
  output logic transfer_interrupt_line_out,
  output logic error_interrupt_line_out
);

  logic [31:0] aom_mem [0:cosir_pkg::AOM_DEPTH-1];
  logic power_on_q = 1'b1;
  logic reinit;
  logic state_change;
  logic [2:0] ovr_sync_q;
  logic ovr_level_q;
  logic ovr_rise;
  logic rx_overrun_q;
  logic [13:0] cfg_q;
  logic [15:0] irq_q;
  logic [15:0] irq_set;
  logic [15:0] irq_clr;
  logic [15:0] mask_q;
  logic mem_en_q;
  logic mem_single_q;
  logic mem_double_q;
  logic [31:0] rdata_q;
  logic aom_hit;
  logic aom_private;
  logic [31:0] status_word;

  function automatic logic wr_at(input logic [12:0] a);
    wr_at = reg_wr_in && (reg_addr_in == a);
  endfunction : wr_at

  // Power-on flag drops after the first cycle; node id caught then.
  always_ff @(posedge clk_sys_in) begin
    power_on_q <= 1'b0;
  end

  assign reinit = srst_in || power_on_q || reset_app_in || bus_switch_in;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in || power_on_q) begin
      node_id_out <= node_id_pins_in;
    end
  end

  cosir_node_state u_node_state (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in || power_on_q),
    .self_start_flag_in(self_start_flag_in),
    .init_done_in(init_done_in),
    .state_req_in(state_req_in),
    .state_req_valid_in(state_req_valid_in),
    .node_state_out(node_state_out),
    .state_change_out(state_change)
  );

  // Overrun crosses through three stages; a level counts once the last two agree.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ovr_sync_q <= 3'h0;
      ovr_level_q <= 1'b0;
    end else begin
      ovr_sync_q <= {ovr_sync_q[1:0], rx_overrun_in};
      if (ovr_sync_q[1] == ovr_sync_q[2]) begin
        ovr_level_q <= ovr_sync_q[2];
      end
    end
  end

  assign ovr_rise = ovr_sync_q[1] && ovr_sync_q[2] && !ovr_level_q;

  always_ff @(posedge clk_sys_in) begin
    if (reinit) begin
      rx_overrun_q <= 1'b0;
    end else if (ovr_rise) begin
      rx_overrun_q <= 1'b1;
    end else if (wr_at(cosir_pkg::ADDR_STATUS) && !reg_wdata_in[cosir_pkg::ST_RX_OVERRUN]) begin
      rx_overrun_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reinit) begin
      cfg_q <= cosir_pkg::CFG_RESET_VAL;
    end else if (wr_at(cosir_pkg::ADDR_CTRL_CFG)) begin
      cfg_q <= reg_wdata_in[13:0] & cosir_pkg::CFG_WRITE_MASK;
    end
  end

  assign can_reset_out = cfg_q[cosir_pkg::CFG_CAN_RESET];
  assign resync_jump_width_out = cfg_q[cosir_pkg::CFG_RJW_LSB +: 3];
  assign bit_timing_out = cfg_q[9:0];

  // Interrupt event set and clear.
  always_comb begin
    irq_set = 16'h0000;
    irq_set[cosir_pkg::IRQ_PDO_RX] = ev_pdo_rx_in;
    irq_set[cosir_pkg::IRQ_PDO_TX] = ev_pdo_tx_in;
    irq_set[cosir_pkg::IRQ_SDO_END] = ev_sdo_end_in;
    irq_set[cosir_pkg::IRQ_SDO_ABORT] = ev_sdo_abort_in;
    irq_set[cosir_pkg::IRQ_SDO_INIT] = ev_sdo_init_in;
    irq_set[cosir_pkg::IRQ_STATE_CHANGE] = state_change;
    irq_set[cosir_pkg::IRQ_MEM_ERR] = mem_single_err_in || mem_double_err_in;
    irq_set[cosir_pkg::IRQ_CAN_ERR] = ovr_rise;
  end

  assign irq_clr = wr_at(cosir_pkg::ADDR_IRQ_MASK_CLR) ?
    (reg_wdata_in[31:16] & cosir_pkg::IRQ_EVENT_SET) : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_irq
      if (cosir_pkg::IRQ_EVENT_SET[gi]) begin : g_ev
        always_ff @(posedge clk_sys_in) begin
          if (reinit) begin
            irq_q[gi] <= 1'b0;
          end else if (irq_set[gi]) begin
            irq_q[gi] <= 1'b1;
          end else if (irq_clr[gi]) begin
            irq_q[gi] <= 1'b0;
          end
        end
      end else if (gi == cosir_pkg::IRQ_SDO_DOWNLOAD) begin : g_dw
        always_ff @(posedge clk_sys_in) begin
          if (reinit) begin
            irq_q[gi] <= 1'b0;
          end else begin
            irq_q[gi] <= sdo_download_in;
          end
        end
      end else if (gi == cosir_pkg::IRQ_SDO_UPLOAD) begin : g_up
        always_ff @(posedge clk_sys_in) begin
          if (reinit) begin
            irq_q[gi] <= 1'b0;
          end else begin
            irq_q[gi] <= sdo_upload_in;
          end
        end
      end else begin : g_rsv
        assign irq_q[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (reinit) begin
      mask_q <= 16'h0000;
    end else if (wr_at(cosir_pkg::ADDR_IRQ_MASK_CLR)) begin
      mask_q <= reg_wdata_in[15:0] & cosir_pkg::IRQ_EVENT_SET;
    end
  end

  assign transfer_interrupt_line_out =
    |(irq_q & ~mask_q & cosir_pkg::IRQ_TRANSFER_SET);
  assign error_interrupt_line_out =
    |(irq_q & ~mask_q & cosir_pkg::IRQ_ERROR_SET);

  // Memory error register.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || power_on_q) begin
      mem_en_q <= 1'b0;
    end else if (wr_at(cosir_pkg::ADDR_MEM_ERR)) begin
      mem_en_q <= reg_wdata_in[cosir_pkg::ME_ENABLE];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reinit) begin
      mem_single_q <= 1'b0;
      mem_double_q <= 1'b0;
    end else begin
      if (mem_single_err_in) begin
        mem_single_q <= 1'b1;
      end else if (wr_at(cosir_pkg::ADDR_MEM_ERR)) begin
        mem_single_q <= 1'b0;
      end
      if (mem_double_err_in) begin
        mem_double_q <= 1'b1;
      end else if (wr_at(cosir_pkg::ADDR_MEM_ERR)) begin
        mem_double_q <= 1'b0;
      end
    end
  end

  assign mem_correct_en_out = mem_en_q;

  always_ff @(posedge clk_sys_in) begin
    if (reinit) begin
      tx_pdo_trigger_out <= 1'b0;
    end else begin
      tx_pdo_trigger_out <= wr_at(cosir_pkg::ADDR_TX_TRIGGER);
    end
  end

  // Application object memory.
  assign aom_hit = (reg_addr_in[12:11] == cosir_pkg::ADDR_AOM_BASE[12:11]);
  assign aom_private = reg_addr_in[10:2] <= cosir_pkg::AOM_PRIVATE_END;

  always_ff @(posedge clk_sys_in) begin
    if (reg_wr_in && aom_hit && !aom_private) begin
      aom_mem[reg_addr_in[10:2]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      reg_wr_rejected_out <= 1'b0;
    end else begin
      reg_wr_rejected_out <= reg_wr_in && aom_hit && aom_private;
    end
  end

  assign status_word = {tx_err_cnt_in, rx_err_cnt_in, 4'h0,
    self_start_flag_in, bus_off_in, err_passive_in, 1'b0,
    rx_overrun_q, active_bus_in, node_state_out};

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_q <= cosir_pkg::READ_ZERO;
    end else if (reg_rd_in) begin
      if (aom_hit) begin
        rdata_q <= aom_mem[reg_addr_in[10:2]];
      end else begin
        case (reg_addr_in)
          cosir_pkg::ADDR_NODE_ID: rdata_q <= {24'h000000, node_id_out};
          cosir_pkg::ADDR_CTRL_CFG: rdata_q <= {18'h00000, cfg_q};
          cosir_pkg::ADDR_STATUS: rdata_q <= status_word;
          cosir_pkg::ADDR_IRQ_STATUS: rdata_q <= {16'h0000, irq_q};
          cosir_pkg::ADDR_IRQ_MASK_CLR: rdata_q <= {16'h0000, mask_q};
          cosir_pkg::ADDR_MEM_ERR: rdata_q <= {21'h000000, mem_en_q, mem_double_q,
                                               mem_single_q, 8'h00};
          default: rdata_q <= cosir_pkg::READ_ZERO;
        endcase
      end
    end else begin
      rdata_q <= cosir_pkg::READ_ZERO;
    end
  end

  assign reg_rdata_out = rdata_q;

  chk_mask_blocks_line: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (mask_q[cosir_pkg::IRQ_PDO_RX] && (irq_q & cosir_pkg::IRQ_TRANSFER_SET) == 16'h0001)
    |-> !transfer_interrupt_line_out)
    else $error("Masked event reached transfer line.");

  chk_err_line_level: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (irq_q[cosir_pkg::IRQ_CAN_ERR] && !mask_q[cosir_pkg::IRQ_CAN_ERR])
    |-> error_interrupt_line_out)
    else $error("CAN error did not raise error line.");

  chk_clear_event: assert property (@(posedge clk_sys_in) disable iff (reinit)
    (wr_at(cosir_pkg::ADDR_IRQ_MASK_CLR) && reg_wdata_in[16] && !irq_set[0])
    |=> !irq_q[cosir_pkg::IRQ_PDO_RX])
    else $error("Clear bit did not clear event.");

  chk_set_over_clear: assert property (@(posedge clk_sys_in) disable iff (reinit)
    irq_set[cosir_pkg::IRQ_PDO_TX] |=> irq_q[cosir_pkg::IRQ_PDO_TX])
    else $error("Event lost on clear.");

  chk_overrun_flag: assert property (@(posedge clk_sys_in) disable iff (reinit)
    ovr_rise |=> rx_overrun_q && irq_q[cosir_pkg::IRQ_CAN_ERR])
    else $error("Overrun not recorded.");

  chk_mem_flag_clear: assert property (@(posedge clk_sys_in) disable iff (reinit)
    (wr_at(cosir_pkg::ADDR_MEM_ERR) && !mem_single_err_in) |=> !mem_single_q)
    else $error("Single error flag not cleared by write.");

  chk_trigger_pulse: assert property (@(posedge clk_sys_in) disable iff (reinit)
    wr_at(cosir_pkg::ADDR_TX_TRIGGER) |=> tx_pdo_trigger_out ##1 !tx_pdo_trigger_out
      || $past(wr_at(cosir_pkg::ADDR_TX_TRIGGER), 1) == 1'b0)
    else $error("Trigger did not pulse.");

  chk_private_reject: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (reg_wr_in && aom_hit && aom_private) |=> reg_wr_rejected_out)
    else $error("Private write not rejected.");

  chk_status_counters: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (reg_rd_in && reg_addr_in == cosir_pkg::ADDR_STATUS)
    |=> reg_rdata_out[31:24] == $past(tx_err_cnt_in) && reg_rdata_out[23:16] == $past(rx_err_cnt_in))
    else $error("Counters misread.");

  cov_transfer_irq: cover property (@(posedge clk_sys_in) transfer_interrupt_line_out);
  cov_error_irq: cover property (@(posedge clk_sys_in) error_interrupt_line_out);
  cov_trigger: cover property (@(posedge clk_sys_in) tx_pdo_trigger_out);
  cov_reject: cover property (@(posedge clk_sys_in) reg_wr_rejected_out);

endmodule : cosir_regs

/* cosir_pkg.sv */
package cosir_pkg;

  // Register byte addresses.
  localparam logic [12:0] ADDR_CTRL_CFG = 13'h10a0;
  localparam logic [12:0] ADDR_STATUS = 13'h10a4;
  localparam logic [12:0] ADDR_IRQ_STATUS = 13'h1128;
  localparam logic [12:0] ADDR_IRQ_MASK_CLR = 13'h112c;
  localparam logic [12:0] ADDR_MEM_ERR = 13'h1130;
  localparam logic [12:0] ADDR_TX_TRIGGER = 13'h1134;
  localparam logic [12:0] ADDR_NODE_ID = 13'h1098;

  // Application object memory.
  localparam int AOM_DEPTH = 512;
  localparam int AOM_AW = 9;
  localparam logic [12:0] ADDR_AOM_BASE = 13'h0000;
  localparam logic [8:0] AOM_PRIVATE_END = 9'h03f;

  // Status register field positions.
  localparam int ST_ACTIVE_BUS = 6;
  localparam int ST_RX_OVERRUN = 7;
  localparam int ST_ERR_PASSIVE = 9;
  localparam int ST_BUS_OFF = 10;
  localparam int ST_SELF_START = 11;
  localparam int ST_RX_ERR_LSB = 16;
  localparam int ST_TX_ERR_LSB = 24;

  // Interrupt status positions.
  localparam int IRQ_PDO_RX = 0;
  localparam int IRQ_PDO_TX = 1;
  localparam int IRQ_SDO_END = 2;
  localparam int IRQ_SDO_ABORT = 3;
  localparam int IRQ_SDO_DOWNLOAD = 9;
  localparam int IRQ_SDO_UPLOAD = 10;
  localparam int IRQ_SDO_INIT = 11;
  localparam int IRQ_STATE_CHANGE = 12;
  localparam int IRQ_MEM_ERR = 14;
  localparam int IRQ_CAN_ERR = 15;
  localparam int IRQ_CLEAR_OFS = 16;
  localparam logic [15:0] IRQ_TRANSFER_SET = 16'h1807;
  localparam logic [15:0] IRQ_ERROR_SET = 16'hc008;
  localparam logic [15:0] IRQ_EVENT_SET = 16'hd80f;

  // Memory error register positions.
  localparam int ME_SINGLE = 8;
  localparam int ME_DOUBLE = 9;
  localparam int ME_ENABLE = 10;

  // Controller configuration positions and reset value.
  localparam int CFG_CAN_RESET = 13;
  localparam int CFG_RJW_LSB = 10;
  localparam logic [13:0] CFG_RESET_VAL = 14'h2000;
  localparam logic [13:0] CFG_WRITE_MASK = 14'h3fff;

  // Node state one-hot codes.
  typedef enum logic [5:0] {
    COSIR_NS_INIT = 6'h01,
    COSIR_NS_RESET_APP = 6'h02,
    COSIR_NS_RESET_COMM = 6'h04,
    COSIR_NS_PREOP = 6'h08,
    COSIR_NS_OPER = 6'h10,
    COSIR_NS_STOPPED = 6'h20
  } cosir_node_state_e;

  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : cosir_pkg

/* cosir_node_state.sv */
`timescale 1ns/1ps
// Node management state machine.
module cosir_node_state (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Control.
  input wire logic self_start_flag_in,
  input wire logic init_done_in,
  input wire logic [5:0] state_req_in,
  input wire logic state_req_valid_in,
  // Status.
  output logic [5:0] node_state_out,
  output logic state_change_out
);

  cosir_pkg::cosir_node_state_e state_q;
  cosir_pkg::cosir_node_state_e state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      cosir_pkg::COSIR_NS_INIT: begin
        if (init_done_in) begin
          state_d = self_start_flag_in ? cosir_pkg::COSIR_NS_OPER :
                    cosir_pkg::COSIR_NS_PREOP;
        end
      end
      default: begin
        if (state_req_valid_in && $onehot(state_req_in)) begin
          state_d = cosir_pkg::cosir_node_state_e'(state_req_in);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q <= cosir_pkg::COSIR_NS_INIT;
      state_change_out <= 1'b0;
    end else begin
      state_q <= state_d;
      state_change_out <= (state_d != state_q);
    end
  end

  assign node_state_out = state_q;

  chk_self_start_oper: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (state_q == cosir_pkg::COSIR_NS_INIT && init_done_in && self_start_flag_in)
    |=> state_q == cosir_pkg::COSIR_NS_OPER)
    else $error("Self start did not reach operational.");

  chk_state_onehot: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $onehot(node_state_out))
    else $error("Node state is not one-hot.");

endmodule : cosir_node_state

/* cosir_host.sv */
`timescale 1ns/1ps
// Host model: register port master and interrupt service.
module cosir_host (
  // Clock.
  input wire logic clk_sys_in,
  // Register port.
  output logic [12:0] reg_addr_out,
  output logic [31:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [31:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 13'h0000;
    reg_wdata_out = 32'h0000_0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // One-cycle write; released data is scrambled so stale values never match.
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
    #1;
  endtask : wr

  // One-cycle read; data is taken in the following cycle.
  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    #1;
    d = reg_rdata_in;
  endtask : rd

  // Service: read the events, drop the overrun first, then clear.
  task automatic ack(input logic [31:0] clr, output logic [31:0] st);
    rd(cosir_pkg::ADDR_IRQ_STATUS, st);
    if (st[15] === 1'b1) begin
      wr(cosir_pkg::ADDR_STATUS, 32'h0000_0000);
    end
    wr(cosir_pkg::ADDR_IRQ_MASK_CLR, clr);
  endtask : ack
endmodule : cosir_host

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in;
  logic srst_in = 1'b1;
  logic [15:0] ev = 16'h0000;
  logic act = 1'b0;
  logic pas = 1'b0;
  logic boff = 1'b0;
  logic [7:0] rxc = 8'h00;
  logic [7:0] txc = 8'h00;
  logic [12:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic rej;
  logic can_rst;
  logic [2:0] rjw;
  logic [9:0] btime;
  logic mem_en;
  logic trig;
  logic [5:0] nst;
  logic [7:0] nid;
  logic trx;
  logic err;
  logic [31:0] st;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int idx[8] = '{0, 1, 2, 3, 11, 12, 14, 15};
  logic [1:0] lexp[8] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1};

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  cosir_host host (.clk_sys_in(clk_sys_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));

  cosir_regs DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_wr_rejected_out(rej), .reset_app_in(ev[4]), .reset_comm_in(ev[5]),
    .bus_switch_in(ev[6]), .node_id_pins_in(8'h3c), .active_bus_in(act),
    .err_passive_in(pas), .bus_off_in(boff), .rx_err_cnt_in(rxc), .tx_err_cnt_in(txc),
    .rx_overrun_in(ev[15]), .can_reset_out(can_rst), .resync_jump_width_out(rjw),
    .bit_timing_out(btime), .self_start_flag_in(1'b1), .init_done_in(ev[12]),
    .state_req_in(6'h20), .state_req_valid_in(ev[8]), .ev_pdo_rx_in(ev[0]),
    .ev_pdo_tx_in(ev[1]), .ev_sdo_end_in(ev[2]), .ev_sdo_abort_in(ev[3]),
    .ev_sdo_init_in(ev[11]), .sdo_download_in(ev[9]), .sdo_upload_in(ev[10]),
    .mem_single_err_in(ev[14]), .mem_double_err_in(ev[13]), .mem_correct_en_out(mem_en),
    .tx_pdo_trigger_out(trig), .node_state_out(nst), .node_id_out(nid),
    .transfer_interrupt_line_out(trx), .error_interrupt_line_out(err));

  task automatic give_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [12:0] a, input logic [31:0] exp);
    host.rd(a, st);
    chk(st, exp);
  endtask : rc

  task automatic pulse(input int i);
    @(posedge clk_sys_in);
    ev[i] <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    ev[i] <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    #1;
  endtask : pulse

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rc(cosir_pkg::ADDR_STATUS, 32'h0000_0801);
    rc(cosir_pkg::ADDR_CTRL_CFG, 32'h0000_2000);
    rc(cosir_pkg::ADDR_MEM_ERR, 32'h0000_0000);
    rc(13'h1200, 32'h0000_0000);
    chk({24'h0, nid}, 32'h0000_003c);
    $display("test reset done");
    @(posedge clk_sys_in);
    act <= 1'b1;
    pas <= 1'b1;
    boff <= 1'b1;
    rxc <= 8'h12;
    txc <= 8'hf0;
    rc(cosir_pkg::ADDR_STATUS, 32'hf012_0e41);
    $display("test status done");
    for (int k = 0; k < 8; k++) begin
      pulse(idx[k]);
      rc(cosir_pkg::ADDR_IRQ_STATUS, 32'h1 << idx[k]);
      chk({30'h0, trx, err}, {30'h0, lexp[k]});
      if (idx[k] == 12) chk({26'h0, nst}, 32'h0000_0010);
      if (idx[k] == 15) rc(cosir_pkg::ADDR_STATUS, 32'hf012_0ed0);
      host.ack(32'h1 << (idx[k] + 16), st);
      chk({30'h0, trx, err}, 32'h0);
      rc(cosir_pkg::ADDR_IRQ_STATUS, 32'h0);
    end
    rc(cosir_pkg::ADDR_STATUS, 32'hf012_0e50);
    $display("test events done");
    host.wr(cosir_pkg::ADDR_IRQ_MASK_CLR, 32'h0000_0001);
    pulse(0);
    chk({30'h0, trx, err}, 32'h0);
    host.wr(cosir_pkg::ADDR_IRQ_MASK_CLR, 32'h0000_0000);
    chk({30'h0, trx, err}, 32'h2);
    host.ack(32'h0001_0000, st);
    pulse(8);
    chk({26'h0, nst}, 32'h0000_0020);
    host.ack(32'h1000_0000, st);
    $display("test mask done");
    @(posedge clk_sys_in);
    ev[9] <= 1'b1;
    rc(cosir_pkg::ADDR_IRQ_STATUS, 32'h0000_0200);
    @(posedge clk_sys_in);
    ev[9] <= 1'b0;
    ev[10] <= 1'b1;
    rc(cosir_pkg::ADDR_IRQ_STATUS, 32'h0000_0400);
    chk({30'h0, trx, err}, 32'h0);
    @(posedge clk_sys_in);
    ev[10] <= 1'b0;
    pulse(13);
    rc(cosir_pkg::ADDR_MEM_ERR, 32'h0000_0300);
    chk({30'h0, trx, err}, 32'h1);
    host.wr(cosir_pkg::ADDR_MEM_ERR, 32'h0000_0700);
    rc(cosir_pkg::ADDR_MEM_ERR, 32'h0000_0400);
    chk({31'h0, mem_en}, 32'h1);
    host.ack(32'h4000_0000, st);
    $display("test memory error done");
    host.wr(cosir_pkg::ADDR_TX_TRIGGER, 32'h0000_0000);
    chk({31'h0, trig}, 32'h1);
    @(posedge clk_sys_in);
    #1;
    chk({31'h0, trig}, 32'h0);
    host.wr(cosir_pkg::ADDR_CTRL_CFG, 32'h0000_1c00);
    chk({18'h0, can_rst, rjw, btime}, 32'h0000_1c00);
    host.wr(13'h0004, 32'h1234_5678);
    chk({31'h0, rej}, 32'h1);
    host.wr(13'h0100, 32'h1234_5678);
    chk({31'h0, rej}, 32'h0);
    $display("test write paths done");
    host.wr(cosir_pkg::ADDR_IRQ_MASK_CLR, 32'h0000_0002);
    pulse(1);
    pulse(5);
    rc(cosir_pkg::ADDR_IRQ_MASK_CLR, 32'h0000_0002);
    rc(cosir_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    pulse(6);
    rc(cosir_pkg::ADDR_IRQ_MASK_CLR, 32'h0);
    rc(cosir_pkg::ADDR_IRQ_STATUS, 32'h0);
    rc(cosir_pkg::ADDR_CTRL_CFG, 32'h0000_2000);
    rc(cosir_pkg::ADDR_MEM_ERR, 32'h0000_0400);
    host.wr(cosir_pkg::ADDR_IRQ_MASK_CLR, 32'h0000_0002);
    pulse(4);
    rc(cosir_pkg::ADDR_IRQ_MASK_CLR, 32'h0);
    chk({26'h0, nst}, 32'h0000_0020);
    $display("test reset events done");
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rc(cosir_pkg::ADDR_MEM_ERR, 32'h0);
    chk({26'h0, nst}, 32'h0000_0001);
    $display("test core reset done");
    give_verdict();
  end
endmodule : testbench
